//--- src/svc_map.vh
// Constants for the service-mode command interpreter: characters,
// answer codes, factory values and limits.
// Assumes inclusion by svc_cmd_interp.v, svc_save_counter.v and the property and test files, not the flash model.
`ifndef SVC_MAP_VH
`define SVC_MAP_VH

// ****************************************
// Characters of the command language
// ****************************************
`define CH_CR        8'h0d
`define CH_SPACE     8'h20
`define CH_COMMA     8'h2c
`define CH_RESTORE   8'h7a
`define CH_SYSCFG    8'h68
`define CH_SAVE_ARG  8'h73
`define CH_YES       8'h59
`define CH_SEL_VOLT  8'h56
`define CH_SEL_VOLTL 8'h76
`define CH_SEL_TOGL  8'h74
`define CH_SEL_BIAS  8'h62
`define CH_DIG_0     8'h30
`define CH_DIG_1     8'h31
`define CH_DIG_3     8'h33
`define CH_DIG_5     8'h35

// ****************************************
// Answer codes on the response port
// ****************************************
`define RSP_CONFIRM      4'h1
`define RSP_CONFIRM_SAVE 4'h2
`define RSP_TX_CONFIRM   4'h3
`define RSP_APPLIED      4'h4
`define RSP_APPLIED_SAVE 4'h5
`define RSP_ABORTED      4'h6
`define RSP_SYSCFG_ECHO  4'h7
`define RSP_E001         4'h9
`define RSP_E002         4'ha
`define RSP_E003         4'hb
`define RSP_E004         4'hc
`define RSP_E005         4'hd

// ****************************************
// Factory values and limits
// ****************************************
`define FACT_BIT_RATE    21'd921600
`define FACT_DATA_BITS   4'd8
`define FACT_STOP_BITS   2'd1
`define FACT_PARITY_EVEN 2'd2
`define FACT_VOLT_5V     1'b1
`define FACT_STROBE_TOGL 1'b1
`define FACT_BIAS_TRIM   1'b1
`define SAVE_LIMIT       16'd1000
`define LINE_KEEP        3'd5

`endif

//--- src/svc_save_counter.v
// Running count of flash saves with the over-limit warning flag.
// Assumes a pulse per successful save on the same clock.
`timescale 1ns/1ps
`include "svc_map.vh"

module svc_save_counter #(
  parameter [15:0] LIMIT = `SAVE_LIMIT
) (
  input  wire        i_clk,
  input  wire        i_rst,
  input  wire        i_inc,    // One-cycle pulse per completed save
  output reg  [15:0] o_count,  // Saves so far
  output reg         o_over    // Count has passed the limit
);

  // ****************************************
  // Counter, saturating so it never wraps to zero
  // ****************************************
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_count <= 16'h0000;
      o_over  <= 1'b0;
    end else if (i_inc && o_count != 16'hffff) begin
      o_count <= o_count + 16'h0001;
      o_over  <= (o_count + 16'h0001) > LIMIT;
    end
  end

endmodule // svc_save_counter

//--- src/svc_cmd_interp.v
// Service-mode interpreter for the factory restore and system
// configuration commands; answers are coded, not spelled out.
// Assumes a receiver on i_clk delivering one byte per i_rx_valid pulse,
// and a flash writer answering each request with one done pulse.
`timescale 1ns/1ps
`include "svc_map.vh"

// How it works
// - Bare restore loads factory values, working only.
// - Restore with s also saves, reports count.
// - Y/N confirmation precedes any factory apply.
// - Changed link settings need second confirmation.
// - Unsaved restore reports applied, advises saving.
// - Unrecognised command letter answers E001.
// - Extra characters after bare restore: E002.
// - Out-of-set parameter value answers E003.
// - Count saves, warn E004 beyond 1000.
// - Failed flash write answers E005.
// - Config change immediate, lost on reset.
// - Voltage setting 5 or 3, else invalid.
// - Strobe toggle setting 1 on, 0 off.
// - Bias-trim datagram setting 1 on, 0 off.
// - Wrong count or leading comma answers E002.
// - Only upper-case Y proceeds, else abort.
module svc_cmd_interp (
  input  wire        i_clk,
  input  wire        i_rst,
  input  wire        i_rx_valid,           // One byte from the host
  input  wire [7:0]  i_rx_char,            // ASCII byte
  input  wire        i_tx_differs,         // Link settings differ from factory
  input  wire        i_flash_done,         // Flash write finished, one pulse
  input  wire        i_flash_ok,           // Result with i_flash_done
  output reg         o_rsp_valid,          // One-cycle answer strobe
  output reg  [3:0]  o_rsp_code,           // Answer code
  output reg  [15:0] o_save_count,         // Running save count
  output reg         o_factory_load,       // Pulse: factory values applied
  output reg         o_flash_req,          // Pulse: write config to flash
  output reg         o_volt_5v,            // Outputs 5 V (1) or 3.3 V (0)
  output reg         o_output_valid_strobe_toggle, // Strobe toggles in start-up datagrams
  output reg         o_bias_trim_datagram_en,      // Send bias-trim datagram at start-up
  output reg  [20:0] o_tx_bit_rate,        // Link bit rate after restore
  output reg  [3:0]  o_tx_data_bits,       // Link data length
  output reg  [1:0]  o_tx_stop_bits,       // Link stop bits
  output reg  [1:0]  o_tx_parity           // 0 none, 1 odd, 2 even
);

  // ****************************************
  // States
  // ****************************************
  localparam [1:0] ST_CMD   = 2'b00; // Waiting for a command line
  localparam [1:0] ST_CONF1 = 2'b01; // Waiting for first Y/N line
  localparam [1:0] ST_CONF2 = 2'b10; // Waiting for link Y/N line
  localparam [1:0] ST_FLASH = 2'b11; // Waiting for flash write

  reg  [1:0]  state_q;      // Interpreter state
  reg  [2:0]  len_q;        // Characters in line, saturates at 7
  reg  [7:0]  c0_q;         // Line characters kept for decoding
  reg  [7:0]  c1_q;
  reg  [7:0]  c2_q;
  reg  [7:0]  c3_q;
  reg  [7:0]  c4_q;
  reg         save_q;       // Pending restore also saves
  reg         warn_q;       // E004 owed after the save answer
  reg         inc_q;        // Pulse into the save counter
  wire [15:0] count;        // Counter value
  wire        over;         // Counter past limit
  wire        line_end;     // Carriage return received

  assign line_end = i_rx_valid && i_rx_char == `CH_CR;

  // ****************************************
  // Helpers
  // ****************************************
  // Reply line is exactly one upper-case Y
  function is_yes;
    input [2:0] len;
    input [7:0] ch;
    begin
      is_yes = (len == 3'd1) && (ch == `CH_YES);
    end
  endfunction

  // Value digit is one of two allowed characters
  function in_pair;
    input [7:0] ch;
    input [7:0] a;
    input [7:0] b;
    begin
      in_pair = (ch == a) || (ch == b);
    end
  endfunction

  // ****************************************
  // Save counter
  // ****************************************
  svc_save_counter #(
    .LIMIT (`SAVE_LIMIT)
  ) u_count (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_inc   (inc_q),
    .o_count (count),
    .o_over  (over)
  );

  // ****************************************
  // Line collector
  // ****************************************
  // Only the first five characters are kept; longer lines are
  // recognised by the length alone, which is all the checks need.
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      len_q <= 3'd0;
      c0_q  <= 8'h00;
      c1_q  <= 8'h00;
      c2_q  <= 8'h00;
      c3_q  <= 8'h00;
      c4_q  <= 8'h00;
    end else if (line_end || state_q == ST_FLASH) begin
      len_q <= 3'd0;
    end else if (i_rx_valid) begin
      case (len_q)
        3'd0: c0_q <= i_rx_char;
        3'd1: c1_q <= i_rx_char;
        3'd2: c2_q <= i_rx_char;
        3'd3: c3_q <= i_rx_char;
        3'd4: c4_q <= i_rx_char;
        default: ;
      endcase
      if (len_q != 3'd7) begin
        len_q <= len_q + 3'd1;
      end
    end
  end

  // ****************************************
  // Command decoding and sequencing
  // ****************************************
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      // Reset returns the working settings to factory values
      state_q                      <= ST_CMD;
      save_q                       <= 1'b0;
      warn_q                       <= 1'b0;
      inc_q                        <= 1'b0;
      o_rsp_valid                  <= 1'b0;
      o_rsp_code                   <= 4'h0;
      o_save_count                 <= 16'h0000;
      o_factory_load               <= 1'b0;
      o_flash_req                  <= 1'b0;
      o_volt_5v                    <= `FACT_VOLT_5V;
      o_output_valid_strobe_toggle <= `FACT_STROBE_TOGL;
      o_bias_trim_datagram_en      <= `FACT_BIAS_TRIM;
      o_tx_bit_rate                <= `FACT_BIT_RATE;
      o_tx_data_bits               <= `FACT_DATA_BITS;
      o_tx_stop_bits               <= `FACT_STOP_BITS;
      o_tx_parity                  <= `FACT_PARITY_EVEN;
    end else begin
      // Pulses default low
      o_rsp_valid    <= 1'b0;
      o_factory_load <= 1'b0;
      o_flash_req    <= 1'b0;
      inc_q          <= 1'b0;
      o_save_count   <= count;
      // Warning follows the save answer two cycles later
      if (warn_q) begin
        warn_q      <= 1'b0;
        o_rsp_valid <= 1'b1;
        o_rsp_code  <= `RSP_E004;
      end
      case (state_q)
        ST_CMD: begin
          if (line_end && len_q != 3'd0) begin
            o_rsp_valid <= 1'b1;
            if (c0_q == `CH_RESTORE) begin
              if (len_q == 3'd1) begin
                save_q     <= 1'b0;
                o_rsp_code <= `RSP_CONFIRM;
                state_q    <= ST_CONF1;
              end else if (len_q == 3'd3 && c1_q == `CH_SPACE &&
                           c2_q == `CH_SAVE_ARG) begin
                save_q     <= 1'b1;
                o_rsp_code <= `RSP_CONFIRM_SAVE;
                state_q    <= ST_CONF1;
              end else if (len_q == 3'd3 && c1_q == `CH_SPACE) begin
                o_rsp_code <= `RSP_E003;
              end else begin
                o_rsp_code <= `RSP_E002;
              end
            end else if (c0_q == `CH_SYSCFG) begin
              // Exact shape: letter, space, selector, comma, value
              if (len_q != 3'd5 || c1_q != `CH_SPACE || c3_q != `CH_COMMA) begin
                o_rsp_code <= `RSP_E002;
              end else begin
                o_rsp_code <= `RSP_SYSCFG_ECHO;
                if (c2_q == `CH_SEL_VOLT || c2_q == `CH_SEL_VOLTL) begin
                  if (in_pair(c4_q, `CH_DIG_5, `CH_DIG_3)) begin
                    o_volt_5v <= (c4_q == `CH_DIG_5);
                  end else begin
                    o_rsp_code <= `RSP_E003;
                  end
                end else if (c2_q == `CH_SEL_TOGL) begin
                  if (in_pair(c4_q, `CH_DIG_0, `CH_DIG_1)) begin
                    o_output_valid_strobe_toggle <= (c4_q == `CH_DIG_1);
                  end else begin
                    o_rsp_code <= `RSP_E003;
                  end
                end else if (c2_q == `CH_SEL_BIAS) begin
                  if (in_pair(c4_q, `CH_DIG_0, `CH_DIG_1)) begin
                    o_bias_trim_datagram_en <= (c4_q == `CH_DIG_1);
                  end else begin
                    o_rsp_code <= `RSP_E003;
                  end
                end else begin
                  // Unknown selector is a bad parameter value
                  o_rsp_code <= `RSP_E003;
                end
              end
            end else begin
              o_rsp_code <= `RSP_E001;
            end
          end
        end
        ST_CONF1: begin
          if (line_end) begin
            o_rsp_valid <= 1'b1;
            if (!is_yes(len_q, c0_q)) begin
              o_rsp_code <= `RSP_ABORTED;
              state_q    <= ST_CMD;
            end else if (i_tx_differs) begin
              o_rsp_code <= `RSP_TX_CONFIRM;
              state_q    <= ST_CONF2;
            end else begin
              o_factory_load <= 1'b1;
              o_volt_5v                    <= `FACT_VOLT_5V;
              o_output_valid_strobe_toggle <= `FACT_STROBE_TOGL;
              o_bias_trim_datagram_en      <= `FACT_BIAS_TRIM;
              if (save_q) begin
                o_rsp_valid <= 1'b0;
                o_flash_req <= 1'b1;
                state_q     <= ST_FLASH;
              end else begin
                o_rsp_code <= `RSP_APPLIED;
                state_q    <= ST_CMD;
              end
            end
          end
        end
        ST_CONF2: begin
          if (line_end) begin
            if (!is_yes(len_q, c0_q)) begin
              o_rsp_valid <= 1'b1;
              o_rsp_code  <= `RSP_ABORTED;
              state_q     <= ST_CMD;
            end else begin
              // Link and working settings both return to factory
              o_factory_load               <= 1'b1;
              o_volt_5v                    <= `FACT_VOLT_5V;
              o_output_valid_strobe_toggle <= `FACT_STROBE_TOGL;
              o_bias_trim_datagram_en      <= `FACT_BIAS_TRIM;
              o_tx_bit_rate                <= `FACT_BIT_RATE;
              o_tx_data_bits               <= `FACT_DATA_BITS;
              o_tx_stop_bits               <= `FACT_STOP_BITS;
              o_tx_parity                  <= `FACT_PARITY_EVEN;
              if (save_q) begin
                o_flash_req <= 1'b1;
                state_q     <= ST_FLASH;
              end else begin
                o_rsp_valid <= 1'b1;
                o_rsp_code  <= `RSP_APPLIED;
                state_q     <= ST_CMD;
              end
            end
          end
        end
        ST_FLASH: begin
          // Host input is ignored until the write ends
          if (i_flash_done) begin
            o_rsp_valid <= 1'b1;
            state_q     <= ST_CMD;
            if (i_flash_ok) begin
              inc_q      <= 1'b1;
              o_rsp_code <= `RSP_APPLIED_SAVE;
            end else begin
              o_rsp_code <= `RSP_E005;
            end
          end
        end
        default: state_q <= ST_CMD;
      endcase
      // Warning owed when this save takes the count past the limit.
      // The counter steps on this same edge, so its value here is still
      // the old one: test it one ahead instead of losing the first warning.
      if (inc_q && (over || count == `SAVE_LIMIT)) begin
        warn_q <= 1'b1;
      end
    end
  end

endmodule // svc_cmd_interp

//--- verif/flash_model.sv
// Flash writer standing behind the interpreter's save requests.
// Assumes one request pulse per save; the bench chooses the outcome.
`timescale 1ns/1ps

module flash_model #(
  parameter int DELAY = 3 // Cycles from request to done
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_req,  // Write request pulse
  input  wire logic i_fail, // Bench asks for a failed write
  output logic      o_done, // One-cycle completion pulse
  output logic      o_ok    // Result, valid with o_done only
);
  // ****************************************
  // Write timing
  // ****************************************
  int cnt; // Cycles left of the write

  // Result line toggles outside done so a stale value never looks valid
  always @(negedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt <= 0;
      o_done <= 1'b0;
      o_ok <= 1'b0;
    end else begin
      o_done <= 1'b0;
      o_ok <= ~o_ok;
      if (i_req === 1'b1) begin
        cnt <= DELAY;
      end else if (cnt == 1) begin
        o_done <= 1'b1;
        o_ok <= ~i_fail;
        cnt <= 0;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule // flash_model

//--- verif/svc_cmd_interp_properties.sv
// Port relations of the service command interpreter.
// Assumes a bind onto svc_cmd_interp; one clock domain.
`timescale 1ns/1ps
`include "svc_map.vh"

module svc_cmd_interp_checker (
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic        i_flash_done,
  input wire logic        i_flash_ok,
  input wire logic        o_rsp_valid,
  input wire logic [3:0]  o_rsp_code,
  input wire logic [15:0] o_save_count,
  input wire logic        o_factory_load,
  input wire logic        o_flash_req,
  input wire logic [20:0] o_tx_bit_rate,
  input wire logic [1:0]  o_tx_parity
);
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  save_answer_a: assert property (i_flash_done && i_flash_ok |=>
    o_rsp_valid && o_rsp_code == `RSP_APPLIED_SAVE) else $error("no saved answer");
  save_fail_a: assert property (i_flash_done && !i_flash_ok |=>
    o_rsp_valid && o_rsp_code == `RSP_E005) else $error("no save error answer");
  count_step_a: assert property (i_flash_done && i_flash_ok |->
    ##3 o_save_count == $past(o_save_count, 3) + 16'h1) else $error("count not stepped");
  count_hold_a: assert property (i_flash_done && !i_flash_ok |->
    ##2 o_save_count == $past(o_save_count, 2)) else $error("count moved on failure");
  warn_over_a: assert property (o_rsp_valid && o_rsp_code == `RSP_APPLIED_SAVE &&
    o_save_count >= `SAVE_LIMIT |-> ##2 o_rsp_valid && o_rsp_code == `RSP_E004)
    else $error("no limit warning");
  load_with_apply_a: assert property (o_rsp_valid && o_rsp_code == `RSP_APPLIED |->
    o_factory_load || $past(o_factory_load)) else $error("applied without load");
  link_factory_a: assert property (o_factory_load |=>
    o_tx_bit_rate == `FACT_BIT_RATE && o_tx_parity == `FACT_PARITY_EVEN)
    else $error("link not factory after load");
  req_pulse_a: assert property (o_flash_req |=> !o_flash_req)
    else $error("flash request longer than one cycle");
endmodule // svc_cmd_interp_checker

//--- verif/service_factory_restore_sysconfig_test.sv
// Self-checking bench for the restore and configuration interpreter.
// Assumes src/ on the include path and the flash model beside it.
`timescale 1ns/1ps
`include "svc_map.vh"

module service_factory_restore_sysconfig_test;
  // ****************************************
  // Design, partner and clock
  // ****************************************
  logic        i_clk, i_rst, i_rx_valid, i_tx_differs, fail;
  logic [7:0]  i_rx_char;
  wire         i_flash_done, i_flash_ok, o_rsp_valid, o_factory_load, o_flash_req;
  wire         o_volt_5v, o_output_valid_strobe_toggle, o_bias_trim_datagram_en;
  wire  [3:0]  o_rsp_code, o_tx_data_bits;
  wire  [15:0] o_save_count;
  wire  [20:0] o_tx_bit_rate;
  wire  [1:0]  o_tx_stop_bits, o_tx_parity;
  int          n_errors, n_compared, n_load, n_req;

  svc_cmd_interp svc_cmd_interp_inst (.i_clk, .i_rst, .i_rx_valid, .i_rx_char,
    .i_tx_differs, .i_flash_done, .i_flash_ok, .o_rsp_valid, .o_rsp_code, .o_save_count,
    .o_factory_load, .o_flash_req, .o_volt_5v, .o_output_valid_strobe_toggle,
    .o_bias_trim_datagram_en, .o_tx_bit_rate, .o_tx_data_bits, .o_tx_stop_bits,
    .o_tx_parity);
  flash_model flash_model_inst (.i_clk, .i_rst, .i_req(o_flash_req), .i_fail(fail),
    .o_done(i_flash_done), .o_ok(i_flash_ok));

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  // Pulse counters, so a missed or doubled pulse shows up
  always @(posedge i_clk) begin
    if (o_factory_load === 1'b1) n_load++;
    if (o_flash_req === 1'b1) n_req++;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string what, input logic [20:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, got);
    end
  endtask

  // Looks on falling edges, where the one-cycle answer stands settled,
  // then lets one more falling edge pass so a pulse is never seen twice
  task automatic expect_rsp(input logic [3:0] exp);
    int k;
    k = 0;
    while (k < 40 && o_rsp_valid !== 1'b1) begin
      @(negedge i_clk);
      k++;
    end
    chk("rsp_code", {17'h0, exp}, {17'h0, o_rsp_valid === 1'b1 ? o_rsp_code : 4'hx});
    @(negedge i_clk);
  endtask

  // Bytes back to back, carriage return appended
  task automatic cmd(input string s, input logic [3:0] code);
    int i;
    for (i = 0; i <= s.len(); i++) begin
      @(negedge i_clk);
      i_rx_valid = 1'b1;
      i_rx_char = (i == s.len()) ? `CH_CR : s[i];
    end
    @(negedge i_clk);
    i_rx_valid = 1'b0;
    expect_rsp(code);
  endtask

  task automatic save(input logic f, input logic [3:0] code);
    @(negedge i_clk);
    fail = f;
    cmd("z s", `RSP_CONFIRM_SAVE);
    cmd("Y", code);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_syscfg;
    chk("bit_rate", `FACT_BIT_RATE, o_tx_bit_rate);
    cmd("h V,3", `RSP_SYSCFG_ECHO);
    chk("volt", 21'h0, {20'h0, o_volt_5v});
    cmd("h v,5", `RSP_SYSCFG_ECHO);
    chk("volt", 21'h1, {20'h0, o_volt_5v});
    cmd("h t,0", `RSP_SYSCFG_ECHO);
    chk("strobe", 21'h0, {20'h0, o_output_valid_strobe_toggle});
    cmd("h t,1", `RSP_SYSCFG_ECHO);
    chk("strobe", 21'h1, {20'h0, o_output_valid_strobe_toggle});
    cmd("h b,0", `RSP_SYSCFG_ECHO);
    chk("bias", 21'h0, {20'h0, o_bias_trim_datagram_en});
    cmd("h b,1", `RSP_SYSCFG_ECHO);
    chk("bias", 21'h1, {20'h0, o_bias_trim_datagram_en});
    cmd("h V,4", `RSP_E003);
    cmd("h t,2", `RSP_E003);
    cmd("h,V,5", `RSP_E002);
    cmd("h V", `RSP_E002);
    cmd("q", `RSP_E001);
    cmd("H V,5", `RSP_E001);
    chk("count", 21'h0, o_save_count);
    chk("flash_req", 21'h0, n_req);
    $display("test syscfg done");
  endtask

  task automatic test_restore;
    int n;
    cmd("h V,3", `RSP_SYSCFG_ECHO);
    cmd("zs", `RSP_E002);
    cmd("z x", `RSP_E003);
    cmd("z", `RSP_CONFIRM);
    cmd("y", `RSP_ABORTED);
    chk("volt", 21'h0, {20'h0, o_volt_5v});
    n = n_req;
    cmd("z", `RSP_CONFIRM);
    cmd("Y", `RSP_APPLIED);
    @(posedge i_clk);
    #1;
    chk("volt", 21'h1, {20'h0, o_volt_5v});
    chk("flash_req", n, n_req);
    @(negedge i_clk);
    i_tx_differs = 1'b1;
    cmd("z", `RSP_CONFIRM);
    cmd("Y", `RSP_TX_CONFIRM);
    cmd("N", `RSP_ABORTED);
    n = n_load;
    cmd("z", `RSP_CONFIRM);
    cmd("Y", `RSP_TX_CONFIRM);
    cmd("Y", `RSP_APPLIED);
    @(posedge i_clk);
    #1;
    chk("loads", n + 1, n_load);
    chk("bits", `FACT_DATA_BITS, o_tx_data_bits);
    chk("stop", `FACT_STOP_BITS, o_tx_stop_bits);
    chk("parity", `FACT_PARITY_EVEN, o_tx_parity);
    @(negedge i_clk);
    i_tx_differs = 1'b0;
    $display("test restore done");
  endtask

  task automatic test_save;
    int i;
    save(1'b0, `RSP_APPLIED_SAVE);
    @(posedge i_clk);
    #1;
    chk("count", 21'h1, o_save_count);
    save(1'b1, `RSP_E005);
    for (i = 2; i <= 1001; i++) save(1'b0, `RSP_APPLIED_SAVE);
    expect_rsp(`RSP_E004);
    save(1'b0, `RSP_APPLIED_SAVE);
    expect_rsp(`RSP_E004);
    chk("count", 21'd1002, o_save_count);
    $display("test save done");
  endtask

  task automatic test_reset;
    cmd("h b,0", `RSP_SYSCFG_ECHO);
    @(negedge i_clk);
    i_rst = 1'b1;
    @(negedge i_clk);
    i_rst = 1'b0;
    chk("bias", 21'h1, {20'h0, o_bias_trim_datagram_en});
    $display("test reset done");
  endtask

  // ****************************************
  // Run and verdict
  // ****************************************
  task automatic give_verdict;
    $display("compared %0d mismatched %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    i_rst = 1'b1;
    i_rx_valid = 1'b0;
    i_rx_char = 8'h00;
    i_tx_differs = 1'b0;
    fail = 1'b0;
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
    i_rst = 1'b0;
    test_syscfg;
    test_restore;
    test_save;
    test_reset;
    give_verdict;
  end

  // About 15k cycles expected; cut off well past that
  initial begin
    #2_000_000;
    n_errors++;
    give_verdict;
  end
endmodule // service_factory_restore_sysconfig_test

bind svc_cmd_interp svc_cmd_interp_checker svc_cmd_interp_checker_inst (.i_clk, .i_rst,
  .i_flash_done, .i_flash_ok, .o_rsp_valid, .o_rsp_code, .o_save_count, .o_factory_load,
  .o_flash_req, .o_tx_bit_rate, .o_tx_parity);
